// >>> design/adc_input_sel.sv
// register file and input routing for the converter front end
`default_nettype none
`include "adc_sel_defines.svh"
// Contract
// - positive input code n selects input n; small package codes 6..8 reserved
// - a set scan bit includes its input in the scan, clear skips it
// - all scan bits writable; missing input converts the low reference
// - config bit 1 makes pin digital, read enabled, mux to analog ground
// - config bit 0 makes pin analog, read disabled, pin voltage sampled
// - config bit x controls analog input x
// - all 13 config bits read and write; missing inputs have no effect
// - with the converter disabled every shared pin is digital
// - config bits 15..13 ignore writes and read zero
module adc_input_sel #(
	parameter int         N       = `INPUT_CNT,
	parameter logic [N-1:0] PRESENT = 13'h1fff  // inputs bonded on this package
) (
	// clock and reset
	input  wire logic          clk_sys_i,
	input  wire logic          srst_i,
	// avalon slave
	input  wire logic [3:0]    avs_address_i,
	input  wire logic          avs_read_i,
	input  wire logic          avs_write_i,
	input  wire logic [31:0]   avs_writedata_i,
	input  wire logic [3:0]    avs_byteenable_i,
	output logic [31:0]        avs_readdata_o,
	output logic               avs_waitrequest_o,
	output logic [1:0]         avs_response_o,
	// converter side
	input  wire logic          module_disable_i,
	input  wire logic          small_pkg_i,
	input  wire logic          scan_en_i,
	input  wire logic          scan_step_i,
	output logic [N-1:0]       port_read_en_o,
	output logic [N-1:0]       mux_to_analog_ground_o,
	output logic [4:0]         mux_code_o,
	output logic               mux_low_voltage_reference_o,
	output logic               mux_analog_ground_o,
	output logic               code_rsvd_o
);
	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	adc_sel_pkg::avl_req_t req_w;
	logic                  ack_q;
	logic                  acc_w;
	logic                  wr_w;
	logic                  hit_w;

	assign req_w = '{address: avs_address_i, read: avs_read_i,
		write: avs_write_i, writedata: avs_writedata_i};
	assign acc_w = (req_w.read || req_w.write) && !ack_q;
	assign wr_w  = req_w.write && ack_q;
	assign hit_w = (req_w.address == `OFS_CH0_SEL) || (req_w.address == `OFS_SCAN_SEL)
		|| (req_w.address == `OFS_PIN_CFG) || (req_w.address == `OFS_STATUS);
	// one wait cycle, answer on the second
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;

	// accept pulse, so every request sees one wait state
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc_w;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0]  ch0_q;
	logic [N-1:0] scan_mask_q;
	logic [N-1:0] pin_digital_sel_q;
	logic         be_lo_w;
	logic         be_hi_w;

	assign be_lo_w = avs_byteenable_i[0];
	assign be_hi_w = avs_byteenable_i[1];

	// merge a 16-bit write under byte enables
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
		input logic lo, input logic hi);
		return {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
	endfunction

	// zero reset; channel select keeps only bits 7 and 4..0; top bits dropped
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ch0_q             <= `CH0_SEL_RST;
			scan_mask_q       <= `SCAN_SEL_RST;
			pin_digital_sel_q <= `PIN_CFG_RST;
		end else if (wr_w) begin
			if (req_w.address == `OFS_CH0_SEL)
				ch0_q <= merge16(ch0_q, req_w.writedata[15:0], be_lo_w, be_hi_w)
					& 16'h009f;
			if (req_w.address == `OFS_SCAN_SEL)
				scan_mask_q <= N'(merge16(16'(scan_mask_q), req_w.writedata[15:0],
					be_lo_w, be_hi_w));
			if (req_w.address == `OFS_PIN_CFG)
				pin_digital_sel_q <= N'(merge16(16'(pin_digital_sel_q),
					req_w.writedata[15:0], be_lo_w, be_hi_w));
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [31:0] rd_d;
	logic [31:0] rd_q;
	logic [1:0]  resp_q;
	logic [4:0]  slot_w;
	logic        slot_vld_w;

	assign rd_d = (req_w.address == `OFS_CH0_SEL)  ? {16'h0000, ch0_q} :
		(req_w.address == `OFS_SCAN_SEL) ? 32'(scan_mask_q) :
		(req_w.address == `OFS_PIN_CFG)  ? 32'(pin_digital_sel_q) :
		(req_w.address == `OFS_STATUS)   ? {24'h000000, slot_vld_w, code_rsvd_o,
			1'b0, slot_w} : 32'h00000000;

	// registered read data and slave error on unmapped address
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rd_q   <= 32'h00000000;
			resp_q <= 2'h0;
		end else if (acc_w) begin
			rd_q   <= req_w.read ? rd_d : 32'h00000000;
			resp_q <= hit_w ? 2'h0 : 2'h2;
		end
	end

	assign avs_readdata_o = rd_q;
	assign avs_response_o = resp_q;

	// ------------------------------------------------------------
	// pin mode
	// ------------------------------------------------------------
	logic [N-1:0] digital_w;

	// bit x drives pin x; disabled module forces digital
	assign digital_w = module_disable_i ? {N{1'b1}} : pin_digital_sel_q;
	// digital reads port and grounds mux; analog does neither
	assign port_read_en_o = digital_w & PRESENT;
	assign mux_to_analog_ground_o  = digital_w & PRESENT;

	// ------------------------------------------------------------
	// input selection
	// ------------------------------------------------------------
	logic [4:0] pos_w;
	logic [4:0] sel_w;
	logic       missing_w;
	adc_sel_pkg::mux_sel_t mux_q;

	// true when code names no bonded input
	function automatic logic absent(input logic [4:0] c, input logic [N-1:0] p);
		return (c > `CH0_CODE_MAX) || !p[c[3:0]];
	endfunction

	adc_scan_walk #(
		.N (N)
	) u_walk (
		.clk_sys_i  (clk_sys_i),
		.srst_i     (srst_i),
		.run_i      (scan_en_i && !module_disable_i),
		.step_i     (scan_step_i),
		.mask_i     (scan_mask_q),
		.slot_o     (slot_w),
		.slot_vld_o (slot_vld_w)
	);

	// code picks input; scan slot picks masked input
	assign pos_w       = ch0_q[`CH0_POS_LSB +: `CH0_POS_W];
	assign sel_w       = slot_vld_w ? slot_w : pos_w;
	assign code_rsvd_o = small_pkg_i && pos_w >= `RSVD_LO && pos_w <= `RSVD_HI;
	// scan slot without a pin goes to the low reference
	assign missing_w   = absent(sel_w, PRESENT);

	// registered mux selection to the converter
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			mux_q <= '0;
		end else begin
			mux_q.mux_code <= sel_w;
			mux_q.to_low_voltage_reference <= missing_w;
			mux_q.to_analog_ground  <= !missing_w && digital_w[sel_w[3:0]];
		end
	end

	assign mux_code_o  = mux_q.mux_code;
	assign mux_low_voltage_reference_o = mux_q.to_low_voltage_reference;
	assign mux_analog_ground_o  = mux_q.to_analog_ground;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// disabled means all present pins digital
	pin_disable_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		module_disable_i |-> port_read_en_o == PRESENT)
		else $error("disabled module left a pin analog");

	// upper config bits stay zero on read
	cfg_upper_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ack_q && $past(req_w.read) && $past(req_w.address) == `OFS_PIN_CFG
		|-> avs_readdata_o[15:13] == 3'h0)
		else $error("config upper bits read nonzero");

	// scan and config registers zero one cycle after reset
	reset_zero_a: assert property (@(posedge clk_sys_i)
		srst_i |=> scan_mask_q == '0 && pin_digital_sel_q == '0)
		else $error("registers not zero after reset");

	// fixed code lands on mux one cycle later
	pos_route_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!slot_vld_w && !absent(pos_w, PRESENT) |=> mux_code_o == $past(pos_w))
		else $error("positive select not routed");

	// missing input converts the low reference
	low_voltage_reference_sel_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		slot_vld_w && absent(slot_w, PRESENT) |=> mux_low_voltage_reference_o && !mux_analog_ground_o)
		else $error("missing input not sent to low reference");

	// scan slot always a masked input
	scan_member_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		slot_vld_w && $stable(scan_mask_q) |-> scan_mask_q[slot_w[3:0]])
		else $error("scan visited unmasked input");

	// digital present pin grounds the mux
	dig_ground_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!absent(sel_w, PRESENT) && digital_w[sel_w[3:0]] |=> mux_analog_ground_o)
		else $error("digital pin not grounded at mux");

	// analog pin has read path off
	ana_read_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!module_disable_i |-> (port_read_en_o & ~pin_digital_sel_q) == '0)
		else $error("analog pin left read enabled");

	// full config write lands on the answer edge
	cfg_wr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		wr_w && req_w.address == `OFS_PIN_CFG && avs_byteenable_i[1:0] == 2'h3
		|=> pin_digital_sel_q == $past(req_w.writedata[N-1:0]))
		else $error("config write lost");

	// fresh request seen by the slave, and its answer
	sequence bus_req_s;
		(avs_read_i || avs_write_i) && !ack_q;
	endsequence
	sequence bus_ans_s;
		!avs_waitrequest_o;
	endsequence

	// first cycle of a request always waits
	wait_high_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		bus_req_s |-> avs_waitrequest_o)
		else $error("request answered without a wait cycle");

	// answer follows after exactly one wait cycle
	wait_one_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		bus_req_s |=> bus_ans_s)
		else $error("request not answered after one wait cycle");

	// a write does not land in its wait cycle
	wr_early_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		avs_write_i && !ack_q
		|=> $stable(ch0_q) && $stable(scan_mask_q) && $stable(pin_digital_sel_q))
		else $error("write landed before waitrequest fell");

	// read data are zero on a write
	wr_rdata_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ack_q && $past(req_w.write) |-> avs_readdata_o == 32'h00000000)
		else $error("write returned read data");

	// unmapped address answers an error and reads zero
	unmapped_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ack_q && $past(req_w.read) && !$past(hit_w)
		|-> avs_readdata_o == 32'h00000000 && avs_response_o == 2'h2)
		else $error("unmapped read not refused");

	resp_ok_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ack_q && $past(hit_w) |-> avs_response_o == 2'h0)
		else $error("mapped access answered an error");

	// channel register keeps only the select fields
	ch0_field_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(ch0_q & 16'hff60) == 16'h0000)
		else $error("unused channel bits held a one");

	// reserved flag only on the small package gap
	rsvd_flag_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		code_rsvd_o |-> small_pkg_i && pos_w >= `RSVD_LO && pos_w <= `RSVD_HI)
		else $error("reserved flag outside the gap");

	// every scan bit takes a full write
	scan_wr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		wr_w && req_w.address == `OFS_SCAN_SEL && avs_byteenable_i[1:0] == 2'h3
		|=> scan_mask_q == $past(req_w.writedata[N-1:0]))
		else $error("scan write lost");

	// scan bits above the inputs read zero
	scan_upper_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ack_q && $past(req_w.read) && $past(req_w.address) == `OFS_SCAN_SEL
		|-> avs_readdata_o[31:N] == '0)
		else $error("scan upper bits read nonzero");

	// bonded scan slot never goes to the low reference
	low_voltage_reference_clr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		slot_vld_w && !absent(slot_w, PRESENT) |=> !mux_low_voltage_reference_o)
		else $error("bonded input sent to low reference");

	// config read returns the stored bits
	cfg_rd_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ack_q && $past(req_w.read) && $past(req_w.address) == `OFS_PIN_CFG
		|-> avs_readdata_o[N-1:0] == $past(pin_digital_sel_q))
		else $error("config read back wrong");

	// pins without an input stay untouched
	unbonded_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(port_read_en_o & ~PRESENT) == '0 && (mux_to_analog_ground_o & ~PRESENT) == '0)
		else $error("unbonded pin driven");

	// enabled module follows the config bit per pin
	pin_follow_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!module_disable_i |-> port_read_en_o == (pin_digital_sel_q & PRESENT))
		else $error("pin mode does not follow its bit");

	// read enable and mux ground go together
	analog_ground_pair_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		mux_to_analog_ground_o == port_read_en_o)
		else $error("mux ground and read enable differ");

	// analog pin is sampled, not grounded
	ana_mux_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!absent(sel_w, PRESENT) && !digital_w[sel_w[3:0]] |=> !mux_analog_ground_o && !mux_low_voltage_reference_o)
		else $error("analog pin not sampled");

	// disabled module grounds a bonded input at the mux
	dis_mux_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		module_disable_i && !absent(sel_w, PRESENT) |=> mux_analog_ground_o)
		else $error("disabled module left the mux on a pin");

	// scan slot lands on the mux one cycle later
	scan_route_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		slot_vld_w |=> mux_code_o == $past(slot_w))
		else $error("scan slot not routed");

	status_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ack_q && $past(req_w.read) && $past(req_w.address) == `OFS_STATUS
		|-> avs_readdata_o[7] == $past(slot_vld_w) && avs_readdata_o[4:0] == $past(slot_w))
		else $error("status does not show the scan slot");
endmodule
`default_nettype wire

// >>> pkg/adc_sel_defines.svh
// offsets, field positions and reset values of the input select block
`ifndef ADC_SEL_DEFINES_SVH
`define ADC_SEL_DEFINES_SVH

// byte offsets of the four word registers
`define OFS_CH0_SEL       4'h0
`define OFS_SCAN_SEL      4'h4
`define OFS_PIN_CFG       4'h8
`define OFS_STATUS        4'hc

// field layout
`define CH0_POS_LSB       0
`define CH0_POS_W         5
`define CH0_NEG_BIT       7
`define INPUT_CNT         13

// reset values
`define CH0_SEL_RST       16'h0000
`define SCAN_SEL_RST      13'h0000
`define PIN_CFG_RST       13'h0000

// highest input code and the reserved gap on the small package
`define CH0_CODE_MAX      5'h0c
`define RSVD_LO           5'h06
`define RSVD_HI           5'h08

`endif

// >>> pkg/adc_sel_pkg.sv
// types shared by the input select block
`default_nettype none
package adc_sel_pkg;
	// one avalon request from the bus side
	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} avl_req_t;

	// selection handed to the converter mux
	typedef struct packed {
		logic [4:0] mux_code;
		logic       to_low_voltage_reference;
		logic       to_analog_ground;
	} mux_sel_t;

	// scan walker states
	typedef enum logic [1:0] {
		SCAN_IDLE,
		SCAN_RUN
	} scan_state_t;
endpackage
`default_nettype wire

// >>> design/adc_scan_walk.sv
// scan walker that visits masked inputs in ascending order
`default_nettype none
`include "adc_sel_defines.svh"
module adc_scan_walk #(
	parameter int N = `INPUT_CNT
) (
	// clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         srst_i,
	// control
	input  wire logic         run_i,
	input  wire logic         step_i,
	input  wire logic [N-1:0] mask_i,
	// current slot
	output logic [4:0]        slot_o,
	output logic              slot_vld_o
);
	adc_sel_pkg::scan_state_t state_q;
	logic [4:0]               slot_q;
	logic [4:0]               next_w;
	logic                     any_w;

	// lowest set bit above a given index, wrapping to the lowest overall
	function automatic logic [4:0] next_set(input logic [N-1:0] m, input logic [4:0] cur);
		logic [4:0] lo;
		logic [4:0] up;
		logic       fl;
		logic       fu;
		lo = 5'h00;
		up = 5'h00;
		fl = 1'b0;
		fu = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (m[i] && !fl) begin
				lo = 5'(i);
				fl = 1'b1;
			end
			if (m[i] && !fu && 5'(i) > cur) begin
				up = 5'(i);
				fu = 1'b1;
			end
		end
		return fu ? up : lo;
	endfunction

	assign any_w      = |mask_i;
	assign next_w     = next_set(mask_i, (state_q == adc_sel_pkg::SCAN_RUN) ? slot_q : 5'h1f);
	assign slot_o     = slot_q;
	assign slot_vld_o = (state_q == adc_sel_pkg::SCAN_RUN);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_q <= adc_sel_pkg::SCAN_IDLE;
			slot_q  <= 5'h00;
		end else begin
			case (state_q)
				adc_sel_pkg::SCAN_IDLE: begin
					if (run_i && any_w) begin
						state_q <= adc_sel_pkg::SCAN_RUN;
						slot_q  <= next_w;
					end
				end
				adc_sel_pkg::SCAN_RUN: begin
					if (!run_i || !any_w) begin
						state_q <= adc_sel_pkg::SCAN_IDLE;
					end else if (step_i) begin
						slot_q <= next_w;
					end
				end
				default: state_q <= adc_sel_pkg::SCAN_IDLE;
			endcase
		end
	end

	scan_wrap_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		slot_vld_o && step_i && run_i && $stable(mask_i) && (mask_i >> (slot_q + 5'h01)) == '0
		|=> slot_q == next_set(mask_i, 5'h1f))
		else $error("scan did not wrap to lowest input");
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the converter input select block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// input 12 left unbonded so the missing-input paths are reached
	localparam logic [12:0] PRESENT = 13'h0fff;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk_sys_i, srst_i, avs_read_i, avs_write_i;
	logic [3:0]  avs_address_i, avs_byteenable_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic        avs_waitrequest_o, mux_low_voltage_reference_o, mux_analog_ground_o, code_rsvd_o;
	logic [1:0]  avs_response_o;
	logic        module_disable_i, small_pkg_i, scan_en_i, scan_step_i;
	logic [12:0] port_read_en_o, mux_to_analog_ground_o;
	logic [4:0]  mux_code_o;
	logic [33:0] exp_q[$];
	logic [12:0] cfg_v;
	logic [4:0]  slots[4];
	int          n_errors, checks;

	adc_input_sel #(.N(13), .PRESENT(PRESENT)) dut (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
		.module_disable_i(module_disable_i), .small_pkg_i(small_pkg_i),
		.scan_en_i(scan_en_i), .scan_step_i(scan_step_i),
		.port_read_en_o(port_read_en_o), .mux_to_analog_ground_o(mux_to_analog_ground_o),
		.mux_code_o(mux_code_o), .mux_low_voltage_reference_o(mux_low_voltage_reference_o),
		.mux_analog_ground_o(mux_analog_ground_o), .code_rsvd_o(code_rsvd_o));

	// 25 mhz clock
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] be);
		@(posedge clk_sys_i);
		avs_write_i      <= wr;
		avs_read_i       <= !wr;
		avs_address_i    <= a;
		avs_writedata_i  <= d;
		avs_byteenable_i <= be;
		do begin
			@(posedge clk_sys_i);
		end while (avs_waitrequest_o !== 1'b0);
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rd(input logic [3:0] a, input logic [33:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask

	task print_verdict;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// read monitor: compares response and data with the oldest note
	always @(posedge clk_sys_i) begin
		if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
			if (exp_q.size() == 0)
				n_errors++;
			else
				check("readdata", {avs_response_o, avs_readdata_o}, exp_q.pop_front());
		end
	end

	// watchdog
	initial begin
		tick(20000);
		n_errors++;
		print_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{avs_read_i, avs_write_i, module_disable_i, small_pkg_i} = 4'h0;
		{scan_en_i, scan_step_i} = 2'h0;
		avs_address_i = 4'h0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hf;
		n_errors = 0;
		checks = 0;
		void'($urandom(68));
		srst_i = 1'b1;
		tick(8);
		srst_i <= 1'b0;
		// reset values and unmapped address
		rd(4'h0, 34'h0);
		rd(4'h4, 34'h0);
		rd(4'h8, 34'h0);
		check("port_read_en", {21'h0, port_read_en_o}, 34'h0);
		rd(4'h2, {2'b10, 32'h0});
		// random pin configurations
		repeat (4) begin
			cfg_v = 13'($urandom);
			wr(4'h8, {16'($urandom), 3'($urandom), cfg_v});
			rd(4'h8, {21'h0, cfg_v});
			tick(2);
			check("port_read_en", {21'h0, port_read_en_o}, {21'h0, cfg_v & PRESENT});
			check("mux_to_analog_ground", {21'h0, mux_to_analog_ground_o}, {21'h0, cfg_v & PRESENT});
		end
		// low byte lane only
		wr(4'h8, 32'h0);
		bus(1'b1, 4'h8, 32'hffff, 4'h1);
		rd(4'h8, 34'h00ff);
		// converter disabled forces present pins digital
		module_disable_i <= 1'b1;
		tick(2);
		check("port_read_en", {21'h0, port_read_en_o}, {21'h0, PRESENT});
		module_disable_i <= 1'b0;
		// every scan bit writable, upper bits read zero
		wr(4'h4, 32'hffff);
		rd(4'h4, 34'h1fff);
		wr(4'h0, 32'hffff);
		rd(4'h0, 34'h009f);
		// every positive input code on the small package
		cfg_v = 13'h0aaa;
		wr(4'h8, {19'h0, cfg_v});
		small_pkg_i <= 1'b1;
		for (int n = 0; n <= 12; n++) begin
			wr(4'h0, 32'(n));
			tick(3);
			check("mux_code", {29'h0, mux_code_o}, 34'(n));
			check("code_rsvd", {33'h0, code_rsvd_o}, {33'h0, n >= 6 && n <= 8});
			check("mux_low_voltage_reference", {33'h0, mux_low_voltage_reference_o}, {33'h0, !PRESENT[n]});
			check("mux_analog_ground", {33'h0, mux_analog_ground_o}, {33'h0, cfg_v[n] && PRESENT[n]});
		end
		// scan over inputs 2, 5 and 12, then wrap
		wr(4'h4, 32'h1024);
		slots = '{5'h02, 5'h05, 5'h0c, 5'h02};
		scan_en_i <= 1'b1;
		tick(3);
		for (int k = 0; k < 4; k++) begin
			check("scan_slot", {29'h0, mux_code_o}, {29'h0, slots[k]});
			check("scan_low_voltage_reference", {33'h0, mux_low_voltage_reference_o}, {33'h0, slots[k] == 5'h0c});
			rd(4'hc, {26'h0, 3'b100, slots[k]});
			scan_step_i <= 1'b1;
			tick(1);
			scan_step_i <= 1'b0;
			tick(3);
		end
		scan_en_i <= 1'b0;
		tick(2);
		print_verdict();
	end
endmodule
`default_nettype wire
